/* src/mb_pkg.sv */
// Shared constants, byte checksum step and timing figures for both link ends.
package mb_pkg;
   // Clock and default serial timing.
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned BAUD_DEF = 19200;
   localparam int unsigned BIT_CYC_DEF = CLK_HZ / BAUD_DEF;
   localparam int unsigned CHAR_BITS = 10;
   localparam int unsigned GAP_CHARS = 7;
   localparam int unsigned GAP_BITS = GAP_CHARS * CHAR_BITS;
   // Reply timeout seen by the requesting end.
   localparam int unsigned TIMEOUT_MS = 1000;
   localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
   // Frame layout.
   localparam logic [7:0] FN_READ_HOLD = 8'h03;
   localparam logic [3:0] REQ_LEN = 4'h8;
   localparam logic [3:0] RSP_HDR = 4'h3;
   localparam logic [3:0] RSP_MAX = 4'hd;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   // Measurement register map, one 16-bit word per register.
   localparam logic [15:0] REG_FLOW = 16'h0006;
   localparam logic [15:0] REG_CONS = 16'h0008;
   localparam logic [16:0] REG_END = 17'h0000a;
   localparam logic [7:0] DECIMAL_TEN = 8'h0a;

   // One byte of the reflected 16-bit frame checksum.
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage

/* src/mb_link_if.sv */
// Serial link between the requesting end and the measurement responder.
`timescale 1ns/1ps
interface mb_link_if;
   logic req_line;
   logic rsp_line;
   modport master (output req_line, input rsp_line);
   modport slave (input req_line, output rsp_line);
endinterface

/* src/mb_slave_end.sv */
// Measurement responder: serial read-holding-register slave with word-swapped values.
// Summary of operation
// - Default link 19200 baud, 8N1 framing
// - Node address defaults to serial's last two digits
// - Requests and replies use read holding registers function
// - Send 32-bit values as byte 1,0,3,2
// - Big-endian master reorders received bytes to 3,2,1,0
// - Little-endian master reorders received bytes to 0,1,2,3
// - Flow float at six, consumption count at eight
// - Serve one request at a time, no concurrency
// - Bit rate and address reconfigurable at run time
`timescale 1ns/1ps
module mb_slave_end
   import mb_pkg::*;
#(
   parameter int unsigned BIT_CYCLES = BIT_CYC_DEF
) (
   // Clock, reset and enable.
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Serial link.
   mb_link_if.slave link,
   // Measurement values from the sensor core.
   input wire logic [31:0] flow_in,
   input wire logic [31:0] cons_in,
   // Serial number digits, sampled while reset is high.
   input wire logic [3:0] serial_tens_in,
   input wire logic [3:0] serial_ones_in,
   // Run-time configuration port.
   input wire logic cfg_addr_we_in,
   input wire logic [7:0] cfg_addr_in,
   input wire logic cfg_bit_we_in,
   input wire logic [15:0] cfg_bit_cycles_in,
   // Status.
   output logic [7:0] node_addr_out,
   output logic [15:0] bit_cycles_out,
   output logic busy_out,
   output logic served_out,
   output logic dropped_out
);

   typedef enum logic [1:0] {
      ST_RX = 2'b00,
      ST_TX = 2'b01
   } slave_state_t;

   slave_state_t st_q;
   logic [7:0] node_q;
   logic [15:0] bit_q;
   logic rx_act_q;
   logic [15:0] rx_tmr_q;
   logic [3:0] rx_idx_q;
   logic [7:0] rx_sh_q;
   logic rx_stb_q;
   logic [23:0] gap_q;
   logic [3:0] nb_q;
   logic ovf_q;
   logic [15:0] crc_q;
   logic [7:0] buf_q [0:7];
   logic [1:0] base_q;
   logic [2:0] cnt_q;
   logic [31:0] flow_q;
   logic [31:0] cons_q;
   logic [3:0] ti_q;
   logic [15:0] tx_crc_q;
   logic tx_q;
   logic [8:0] tx_sh_q;
   logic [15:0] tx_tmr_q;
   logic [3:0] tx_left_q;
   logic [23:0] gap_lim;
   logic eof;
   logic [15:0] r_start;
   logic [15:0] r_cnt;
   logic [16:0] r_top;
   logic frame_ok;
   logic [3:0] tot;
   logic [7:0] nxt_byte;
   logic [3:0] widx;
   logic [1:0] wsel;
   logic [15:0] word;

   assign link.rsp_line = tx_q;
   assign node_addr_out = node_q;
   assign bit_cycles_out = bit_q;
   assign busy_out = st_q[0];

   // Configuration. The strap digits are caught by a clocked reset, not an async one.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         node_q <= 8'(serial_tens_in) * DECIMAL_TEN + 8'(serial_ones_in);
         bit_q <= 16'(BIT_CYCLES);
      end else if (ce_in) begin
         if (cfg_addr_we_in) begin
            node_q <= cfg_addr_in;
         end
         // A bit-rate change mid-frame garbles that frame only.
         if (cfg_bit_we_in) begin
            bit_q <= cfg_bit_cycles_in;
         end
      end
   end

   // Receiver: 8N1 characters sampled at mid bit; ignored while replying.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         rx_act_q <= 1'b0;
         rx_tmr_q <= 16'h0000;
         rx_idx_q <= 4'h0;
         rx_sh_q <= 8'h00;
         rx_stb_q <= 1'b0;
      end else if (ce_in) begin
         rx_stb_q <= 1'b0;
         if (!rx_act_q) begin
            if (!link.req_line && st_q == ST_RX) begin
               rx_act_q <= 1'b1;
               rx_tmr_q <= bit_q >> 1;
               rx_idx_q <= 4'h0;
            end
         end else if (rx_tmr_q != 16'h0000) begin
            rx_tmr_q <= rx_tmr_q - 16'h0001;
         end else begin
            rx_tmr_q <= bit_q - 16'h0001;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h0 && link.req_line) begin
               rx_act_q <= 1'b0; // False start bit.
            end else if (rx_idx_q == 4'h9) begin
               rx_act_q <= 1'b0;
               rx_stb_q <= link.req_line; // Framing error drops the byte.
            end else if (rx_idx_q != 4'h0) begin
               rx_sh_q <= {link.req_line, rx_sh_q[7:1]};
            end
         end
      end
   end

   // Silence of seven characters closes the request frame.
   assign gap_lim = 24'(bit_q) * 24'(GAP_BITS);
   assign eof = (gap_q == gap_lim) && (nb_q != 4'h0 || ovf_q);

   // Frame collection with running checksum; the checksum bytes bring it to zero.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         gap_q <= 24'h000000;
         nb_q <= 4'h0;
         ovf_q <= 1'b0;
         crc_q <= CRC_INIT;
      end else if (ce_in) begin
         if (eof) begin
            nb_q <= 4'h0;
            ovf_q <= 1'b0;
            crc_q <= CRC_INIT;
         end else if (rx_stb_q) begin
            if (nb_q < REQ_LEN) begin
               buf_q[nb_q[2:0]] <= rx_sh_q;
               nb_q <= nb_q + 4'h1;
            end else begin
               ovf_q <= 1'b1;
            end
            crc_q <= crc_step(crc_q, rx_sh_q);
         end
         if (rx_act_q || rx_stb_q || !link.req_line) begin
            gap_q <= 24'h000000;
         end else if (gap_q != gap_lim) begin
            gap_q <= gap_q + 24'h000001;
         end
      end
   end

   // Request check: length, checksum, own address, function, register span.
   assign r_start = {buf_q[2], buf_q[3]};
   assign r_cnt = {buf_q[4], buf_q[5]};
   assign r_top = {1'b0, r_start} + {1'b0, r_cnt};
   assign frame_ok = (nb_q == REQ_LEN) && !ovf_q && (crc_q == 16'h0000)
      && (buf_q[0] == node_q)
      && (buf_q[1] == FN_READ_HOLD)
      && (r_cnt != 16'h0000) && (r_start >= REG_FLOW) && (r_top <= REG_END);

   // Reply byte selection: header, data words, checksum low then high.
   assign tot = RSP_HDR + 4'({cnt_q, 1'b0}) + 4'h2;
   assign widx = ti_q - RSP_HDR;
   assign wsel = base_q + widx[2:1];
   always_comb begin
      case (wsel)
         2'b00: word = flow_q[15:0]; // Low word goes first.
         2'b01: word = flow_q[31:16];
         2'b10: word = cons_q[15:0];
         default: word = cons_q[31:16];
      endcase
      if (ti_q == 4'h0) begin
         nxt_byte = node_q;
      end else if (ti_q == 4'h1) begin
         nxt_byte = FN_READ_HOLD;
      end else if (ti_q == 4'h2) begin
         nxt_byte = {4'h0, cnt_q, 1'b0};
      end else if (ti_q < tot - 4'h2) begin
         nxt_byte = widx[0] ? word[7:0] : word[15:8];
      end else if (ti_q == tot - 4'h2) begin
         nxt_byte = tx_crc_q[7:0];
      end else begin
         nxt_byte = tx_crc_q[15:8];
      end
   end

   // Reply engine; starts on the frame end itself, so no added delay.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         st_q <= ST_RX;
         base_q <= 2'b00;
         cnt_q <= 3'h0;
         flow_q <= 32'h00000000;
         cons_q <= 32'h00000000;
         ti_q <= 4'h0;
         tx_crc_q <= CRC_INIT;
         tx_q <= 1'b1;
         tx_sh_q <= 9'h1ff;
         tx_tmr_q <= 16'h0000;
         tx_left_q <= 4'h0;
         served_out <= 1'b0;
         dropped_out <= 1'b0;
      end else if (ce_in) begin
         served_out <= 1'b0;
         dropped_out <= 1'b0;
         case (st_q)
            ST_RX: begin
               if (eof && frame_ok) begin
                  st_q <= ST_TX;
                  base_q <= 2'(r_start - REG_FLOW);
                  cnt_q <= 3'(r_cnt);
                  // Snapshot keeps both halves of a value coherent.
                  flow_q <= flow_in;
                  cons_q <= cons_in;
                  ti_q <= 4'h0;
                  tx_crc_q <= CRC_INIT;
               end else if (eof) begin
                  dropped_out <= 1'b1;
               end
            end
            ST_TX: begin
               if (tx_left_q == 4'h0) begin
                  if (ti_q == tot) begin
                     st_q <= ST_RX;
                     served_out <= 1'b1;
                  end else begin
                     tx_q <= 1'b0;
                     tx_sh_q <= {1'b1, nxt_byte};
                     tx_left_q <= 4'(CHAR_BITS);
                     tx_tmr_q <= bit_q - 16'h0001;
                     ti_q <= ti_q + 4'h1;
                     if (ti_q < tot - 4'h2) begin
                        tx_crc_q <= crc_step(tx_crc_q, nxt_byte);
                     end
                  end
               end else if (tx_tmr_q != 16'h0000) begin
                  tx_tmr_q <= tx_tmr_q - 16'h0001;
               end else begin
                  tx_tmr_q <= bit_q - 16'h0001;
                  tx_left_q <= tx_left_q - 4'h1;
                  tx_q <= tx_sh_q[0];
                  tx_sh_q <= {1'b1, tx_sh_q[8:1]};
               end
            end
            default: st_q <= ST_RX;
         endcase
      end
   end

endmodule // mb_slave_end

/* src/mb_master_end.sv */
// Requesting end: sends one read request and reorders the returned values.
`timescale 1ns/1ps
module mb_master_end
   import mb_pkg::*;
#(
   parameter int unsigned BIT_CYCLES = BIT_CYC_DEF,
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   // Clock, reset and enable.
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Serial link.
   mb_link_if.master link,
   // Request port.
   input wire logic req_go_in,
   input wire logic [7:0] req_node_in,
   input wire logic [15:0] req_start_in,
   input wire logic [2:0] req_count_in,
   input wire logic msb_first_in,
   // Result port.
   output logic busy_out,
   output logic done_out,
   output logic err_out,
   output logic [31:0] value0_out,
   output logic [31:0] value1_out
);

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SEND = 2'b01,
      H_WAIT = 2'b10
   } host_state_t;

   host_state_t st_q;
   logic [7:0] rq_q [0:5];
   logic [2:0] cnt_q;
   logic [3:0] ti_q;
   logic [15:0] crc_q;
   logic tx_q;
   logic [8:0] tx_sh_q;
   logic [15:0] tx_tmr_q;
   logic [3:0] tx_left_q;
   logic rx_act_q;
   logic [15:0] rx_tmr_q;
   logic [3:0] rx_idx_q;
   logic [7:0] rx_sh_q;
   logic [23:0] gap_q;
   logic [31:0] to_q;
   logic [3:0] nb_q;
   logic [7:0] buf_q [0:12];
   logic [7:0] nxt_byte;
   logic [23:0] gap_lim;
   logic good;

   assign link.req_line = tx_q;
   assign busy_out = st_q != H_IDLE;
   assign gap_lim = 24'(BIT_CYCLES) * 24'(GAP_BITS);
   assign nxt_byte = (ti_q < 4'h6) ? rq_q[ti_q[2:0]] : (ti_q[0] ? crc_q[15:8] : crc_q[7:0]);
   assign good = (crc_q == 16'h0000) && (buf_q[0] == rq_q[0]) && (buf_q[1] == FN_READ_HOLD)
      && (nb_q == RSP_HDR + 4'({cnt_q, 1'b0}) + 4'h2);

   // Request, reply collection and value reordering; one request at a time.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         st_q <= H_IDLE;
         cnt_q <= 3'h0;
         ti_q <= 4'h0;
         crc_q <= CRC_INIT;
         tx_q <= 1'b1;
         tx_sh_q <= 9'h1ff;
         tx_tmr_q <= 16'h0000;
         tx_left_q <= 4'h0;
         rx_act_q <= 1'b0;
         rx_tmr_q <= 16'h0000;
         rx_idx_q <= 4'h0;
         rx_sh_q <= 8'h00;
         gap_q <= 24'h000000;
         to_q <= 32'h00000000;
         nb_q <= 4'h0;
         done_out <= 1'b0;
         err_out <= 1'b0;
         value0_out <= 32'h00000000;
         value1_out <= 32'h00000000;
      end else if (ce_in) begin
         done_out <= 1'b0;
         case (st_q)
            H_IDLE: begin
               if (req_go_in) begin
                  st_q <= H_SEND;
                  rq_q[0] <= req_node_in;
                  rq_q[1] <= FN_READ_HOLD;
                  rq_q[2] <= req_start_in[15:8];
                  rq_q[3] <= req_start_in[7:0];
                  rq_q[4] <= 8'h00;
                  rq_q[5] <= {5'h00, req_count_in};
                  cnt_q <= req_count_in;
                  ti_q <= 4'h0;
                  crc_q <= CRC_INIT;
               end
            end
            H_SEND: begin
               if (tx_left_q == 4'h0) begin
                  if (ti_q == REQ_LEN) begin
                     st_q <= H_WAIT;
                     crc_q <= CRC_INIT;
                     nb_q <= 4'h0;
                     gap_q <= 24'h000000;
                     to_q <= 32'h00000000;
                  end else begin
                     tx_q <= 1'b0;
                     tx_sh_q <= {1'b1, nxt_byte};
                     tx_left_q <= 4'(CHAR_BITS);
                     tx_tmr_q <= 16'(BIT_CYCLES) - 16'h0001;
                     ti_q <= ti_q + 4'h1;
                     if (ti_q < 4'h6) begin
                        crc_q <= crc_step(crc_q, nxt_byte);
                     end
                  end
               end else if (tx_tmr_q != 16'h0000) begin
                  tx_tmr_q <= tx_tmr_q - 16'h0001;
               end else begin
                  tx_tmr_q <= 16'(BIT_CYCLES) - 16'h0001;
                  tx_left_q <= tx_left_q - 4'h1;
                  tx_q <= tx_sh_q[0];
                  tx_sh_q <= {1'b1, tx_sh_q[8:1]};
               end
            end
            H_WAIT: begin
               to_q <= to_q + 32'h00000001;
               if (!rx_act_q) begin
                  if (!link.rsp_line) begin
                     rx_act_q <= 1'b1;
                     rx_tmr_q <= 16'(BIT_CYCLES) >> 1;
                     rx_idx_q <= 4'h0;
                     gap_q <= 24'h000000;
                  end else if (gap_q != gap_lim) begin
                     gap_q <= gap_q + 24'h000001;
                  end
               end else if (rx_tmr_q != 16'h0000) begin
                  rx_tmr_q <= rx_tmr_q - 16'h0001;
               end else begin
                  rx_tmr_q <= 16'(BIT_CYCLES) - 16'h0001;
                  rx_idx_q <= rx_idx_q + 4'h1;
                  if (rx_idx_q == 4'h0 && link.rsp_line) begin
                     rx_act_q <= 1'b0;
                  end else if (rx_idx_q == 4'h9) begin
                     rx_act_q <= 1'b0;
                     if (link.rsp_line && nb_q < RSP_MAX) begin
                        buf_q[nb_q] <= rx_sh_q;
                        nb_q <= nb_q + 4'h1;
                        crc_q <= crc_step(crc_q, rx_sh_q);
                     end
                  end else if (rx_idx_q != 4'h0) begin
                     rx_sh_q <= {link.rsp_line, rx_sh_q[7:1]};
                  end
               end
               // Wire order is byte 1,0,3,2; rebuild for the chosen storage order.
               if (gap_q == gap_lim && nb_q != 4'h0) begin
                  st_q <= H_IDLE;
                  done_out <= 1'b1;
                  err_out <= !good;
                  if (good && msb_first_in) begin
                     value0_out <= {buf_q[5], buf_q[6], buf_q[3], buf_q[4]};
                     value1_out <= {buf_q[9], buf_q[10], buf_q[7], buf_q[8]};
                  end else if (good) begin
                     value0_out <= {buf_q[4], buf_q[3], buf_q[6], buf_q[5]};
                     value1_out <= {buf_q[8], buf_q[7], buf_q[10], buf_q[9]};
                  end
               end else if (to_q == 32'(TIMEOUT_CYCLES)) begin
                  st_q <= H_IDLE; // No reply: free for the next request.
                  done_out <= 1'b1;
                  err_out <= 1'b1;
               end
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

endmodule // mb_master_end

/* tb/mb_monitor.sv */
// Wire-level checker for the serial link between the two ends.
`timescale 1ns/1ps
module mb_monitor #(
   parameter int unsigned BIT_CYCLES = 16
) (
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Link lines.
   input wire logic req_line,
   input wire logic rsp_line
);
   logic [1:0] act_q;
   logic [7:0] cyc_q [2];
   logic [3:0] bit_q [2];
   logic [15:0] req_idle_q;
   logic [15:0] rsp_idle_q;
   logic [1:0] line;
   logic [7:0] mid;

   // Index 1 follows the request line, index 0 the reply line.
   assign line = {req_line, rsp_line};
   assign mid = 8'(BIT_CYCLES / 2);

   // Each tracker walks one character so start and stop can be probed mid-bit.
   always_ff @(posedge mclk_in) begin
      for (int i = 0; i < 2; i++) begin
         if (sys_rst_in) begin
            act_q[i] <= 1'b0;
         end else if (!act_q[i]) begin
            act_q[i] <= !line[i];
            cyc_q[i] <= 8'h01;
            bit_q[i] <= 4'h0;
         end else if (cyc_q[i] == 8'(BIT_CYCLES - 1)) begin
            cyc_q[i] <= 8'h00;
            bit_q[i] <= bit_q[i] + 4'h1;
            act_q[i] <= (bit_q[i] != 4'h9);
         end else begin
            cyc_q[i] <= cyc_q[i] + 8'h01;
         end
      end
   end

   // Idle run lengths saturate, so a long silence never wraps into a short one.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || !req_line) begin
         req_idle_q <= sys_rst_in ? 16'hffff : 16'h0000;
      end else if (req_idle_q != 16'hffff) begin
         req_idle_q <= req_idle_q + 16'h0001;
      end
   end

   // Reply line idle run.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || !rsp_line) begin
         rsp_idle_q <= sys_rst_in ? 16'hffff : 16'h0000;
      end else if (rsp_idle_q != 16'hffff) begin
         rsp_idle_q <= rsp_idle_q + 16'h0001;
      end
   end

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (sys_rst_in);

   // A frame starts with a fall after a silence longer than any gap between characters.
   sequence s_new_reply;
      $fell(rsp_line) && (rsp_idle_q > 16'h012c);
   endsequence
   sequence s_new_request;
      $fell(req_line) && (req_idle_q > 16'h012c);
   endsequence

   a_idle_after_rst: assert property ($fell(sys_rst_in) |-> req_line && rsp_line)
      else $error("link not idle after reset");
   a_rsp_start_low: assert property (act_q[0] && bit_q[0] == 4'h0 && cyc_q[0] == mid |-> !rsp_line)
      else $error("reply start bit not low mid-bit");
   a_rsp_stop_high: assert property (act_q[0] && bit_q[0] == 4'h9 && cyc_q[0] == mid |-> rsp_line)
      else $error("reply stop bit not high");
   a_req_start_low: assert property (act_q[1] && bit_q[1] == 4'h0 && cyc_q[1] == mid |-> !req_line)
      else $error("request start bit not low mid-bit");
   a_req_stop_high: assert property (act_q[1] && bit_q[1] == 4'h9 && cyc_q[1] == mid |-> req_line)
      else $error("request stop bit not high");
   a_wire_one_talker: assert property (!rsp_line |-> req_line)
      else $error("both ends talking at once");
   a_reply_gap_exact: assert property (s_new_reply |-> req_idle_q >= 16'h044c && req_idle_q <= 16'h0514)
      else $error("reply did not follow a seven character silence");
   a_request_after_gap: assert property (s_new_request |-> rsp_idle_q >= 16'h0460)
      else $error("request sent while a reply was pending");
endmodule // mb_monitor

/* tb/modbus_measurement_slave_tb_top.sv */
// Testbench joining both link ends and checking reads, drops and reconfiguration.
`timescale 1ns/1ps
module modbus_measurement_slave_tb_top;
   localparam int unsigned BITS = 16;
   logic mclk_in, sys_rst_in, req_go_in, msb_first_in, m_busy, m_done, m_err;
   logic [7:0] req_node_in, cfg_addr_in, node_addr;
   logic [15:0] req_start_in, cfg_bit_cycles_in, bit_cycles;
   logic [2:0] req_count_in;
   logic [31:0] value0, value1, flow_in, cons_in;
   logic [3:0] tens, ones;
   logic cfg_addr_we_in, cfg_bit_we_in, s_busy, served, dropped, ce;
   int err_count, checked, served_n, dropped_n, busy_n;

   mb_link_if mb_link_if_i ();
   mb_master_end #(.BIT_CYCLES(BITS), .TIMEOUT_CYCLES(20000)) mb_master_end_i (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce), .link(mb_link_if_i.master),
      .req_go_in(req_go_in), .req_node_in(req_node_in), .req_start_in(req_start_in),
      .req_count_in(req_count_in), .msb_first_in(msb_first_in), .busy_out(m_busy),
      .done_out(m_done), .err_out(m_err), .value0_out(value0), .value1_out(value1));
   mb_slave_end #(.BIT_CYCLES(BITS)) mb_slave_end_i (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce), .link(mb_link_if_i.slave),
      .flow_in(flow_in), .cons_in(cons_in), .serial_tens_in(tens), .serial_ones_in(ones),
      .cfg_addr_we_in(cfg_addr_we_in), .cfg_addr_in(cfg_addr_in), .cfg_bit_we_in(cfg_bit_we_in),
      .cfg_bit_cycles_in(cfg_bit_cycles_in), .node_addr_out(node_addr),
      .bit_cycles_out(bit_cycles), .busy_out(s_busy), .served_out(served), .dropped_out(dropped));
   mb_monitor #(.BIT_CYCLES(BITS)) mb_monitor_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .req_line(mb_link_if_i.req_line), .rsp_line(mb_link_if_i.rsp_line));

   // Free-running 100 MHz clock.
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   // Count reply and discard pulses of the responder during each request.
   always @(posedge mclk_in) begin
      if (served === 1'b1) served_n++;
      if (dropped === 1'b1) dropped_n++;
      if (s_busy === 1'b1) busy_n++;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (err_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // One request; waits for completion under a bound above the master's own timeout.
   task automatic read_regs(input logic [7:0] node, input logic [15:0] start,
                            input logic [2:0] count, input logic msb);
      int n;
      @(negedge mclk_in);
      req_node_in = node;
      req_start_in = start;
      req_count_in = count;
      msb_first_in = msb;
      req_go_in = 1'b1;
      served_n = 0;
      dropped_n = 0;
      busy_n = 0;
      @(negedge mclk_in);
      req_go_in = 1'b0;
      check("requester busy_out", {31'h0, m_busy}, 32'h1);
      n = 0;
      while (m_done !== 1'b1 && n < 30000) begin
         @(negedge mclk_in);
         n++;
      end
      check("done_out", {31'h0, m_done}, 32'h1);
      check("requester idle", {31'h0, m_busy}, 32'h0);
      check("responder idle", {31'h0, s_busy}, 32'h0);
   endtask

   // Config writes are taken on one edge; a full cycle passes before the check.
   task automatic set_config(input logic [7:0] addr, input logic [15:0] bits);
      @(negedge mclk_in);
      cfg_addr_in = addr;
      cfg_bit_cycles_in = bits;
      cfg_addr_we_in = 1'b1;
      cfg_bit_we_in = 1'b1;
      @(negedge mclk_in);
      cfg_addr_we_in = 1'b0;
      cfg_bit_we_in = 1'b0;
      @(negedge mclk_in);
      check("node_addr_out", {24'h0, node_addr}, {24'h0, addr});
      check("bit_cycles_out", {16'h0, bit_cycles}, {16'h0, bits});
   endtask

   // Stops a hung run well after the longest expected sequence.
   initial begin
      #900000;
      err_count++;
      end_of_test();
   end

   initial begin
      sys_rst_in = 1'b1;
      ce = 1'b1;
      req_go_in = 1'b0;
      req_node_in = 8'h00;
      req_start_in = 16'h0000;
      req_count_in = 3'h1;
      msb_first_in = 1'b1;
      cfg_addr_we_in = 1'b0;
      cfg_bit_we_in = 1'b0;
      cfg_addr_in = 8'h00;
      cfg_bit_cycles_in = 16'h0000;
      tens = 4'h4;
      ones = 4'h2;
      flow_in = 32'h42f6e666;
      cons_in = 32'h12345678;
      // Count rising edges so the clock's first step from unknown cannot shorten reset.
      repeat (4) @(posedge mclk_in);
      @(negedge mclk_in);
      sys_rst_in = 1'b0;
      check("node_addr_out", {24'h0, node_addr}, 32'h2a);
      check("bit_cycles_out", {16'h0, bit_cycles}, 32'h10);
      // Both values at once, most significant byte first.
      read_regs(8'h2a, 16'h0006, 3'h4, 1'b1);
      check("err_out", {31'h0, m_err}, 32'h0);
      check("flow value", value0, 32'h42f6e666);
      check("consumption value", value1, 32'h12345678);
      check("reply count", 32'(served_n), 32'h1);
      check("responder busy", {31'h0, busy_n != 0}, 32'h1);
      // Same read, least significant byte first.
      read_regs(8'h2a, 16'h0006, 3'h4, 1'b0);
      check("flow swapped", value0, 32'h66e6f642);
      check("consumption swapped", value1, 32'h78563412);
      // Foreign address: no reply, values hold.
      read_regs(8'h2b, 16'h0006, 3'h4, 1'b1);
      check("err_out", {31'h0, m_err}, 32'h1);
      check("drop count", 32'(dropped_n), 32'h1);
      check("reply count", 32'(served_n), 32'h0);
      check("responder busy", 32'(busy_n), 32'h0);
      check("held value", value0, 32'h66e6f642);
      // Span reaching past the last measurement register is discarded.
      read_regs(8'h2a, 16'h0009, 3'h2, 1'b1);
      check("drop count", 32'(dropped_n), 32'h1);
      // Run-time reconfiguration, then the link rate restored for traffic.
      set_config(8'h07, 16'h0014);
      set_config(8'h07, 16'h0010);
      // Enable low freezes all state, so this configuration write must not land.
      @(negedge mclk_in);
      ce = 1'b0;
      cfg_addr_in = 8'h55;
      cfg_addr_we_in = 1'b1;
      @(negedge mclk_in);
      cfg_addr_we_in = 1'b0;
      ce = 1'b1;
      @(negedge mclk_in);
      check("frozen node_addr_out", {24'h0, node_addr}, 32'h07);
      cons_in = 32'h0000a5c3;
      read_regs(8'h07, 16'h0008, 3'h2, 1'b1);
      check("err_out", {31'h0, m_err}, 32'h0);
      check("consumption value", value0, 32'h0000a5c3);
      end_of_test();
   end
endmodule // modbus_measurement_slave_tb_top
